// *** verilog/i2c_timing_pkg.sv ***
// constants, types and register map of the two-wire bit timing block
`default_nettype none
package i2c_timing_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] DIV_REG_OFS = 8'h00;
  localparam logic [7:0] CTRL_REG_OFS = 8'h04;
  localparam logic [7:0] CMD_REG_OFS = 8'h08;
  localparam logic [7:0] STAT_REG_OFS = 8'h0c;
  localparam logic [7:0] TIME0_REG_OFS = 8'h10;
  localparam logic [7:0] TIME1_REG_OFS = 8'h14;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int DIV_SEL_LSB = 0;
  localparam int FSR_LSB = 8;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_POS = 4;
  localparam int CTRL_EN_POS = 0;
  localparam logic [5:0] DIV_SEL_RESET = 6'h00;
  localparam logic [5:0] FSR_RESET = 6'h10;
  localparam logic CTRL_EN_RESET = 1'b0;

  // ------------------------------------------------------------------
  // timing figures in memory-bus clock cycles, plus divider codes and a halving count
  // ------------------------------------------------------------------
  localparam logic [15:0] HOLD_BASE = 16'h0008;
  localparam logic [15:0] HOLD_UNIT = 16'h0010;
  localparam logic [15:0] SH_LIMIT_LO = 16'h0010;
  localparam logic [15:0] SH_LIMIT_HI = 16'h0009;
  localparam logic [15:0] RATIO_TOP = 16'hf000;
  localparam logic [5:0] CODE_TOP_LO = 6'h1f;
  localparam logic [5:0] CODE_HI_SHIFT0 = 6'h24;
  localparam int SH_HALVINGS = 12;

  // ------------------------------------------------------------------
  // commands, states and bus carrier
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_BIT = 2'b01,
    OP_STOP = 2'b10,
    OP_RESTART = 2'b11
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START_HOLD = 3'b001,
    ST_PARK = 3'b010,
    ST_LOW = 3'b011,
    ST_HIGH = 3'b100
  } state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

endpackage : i2c_timing_pkg
`default_nettype wire

// *** verilog/i2c_bit_timing_divider.sv ***
// two-wire bus bit timing: input filter, divider select and master bit sequencer
//
// Contract
// - Every generated or checked bus interval is a whole count of memory-bus clock cycles.
// - SCL and SDA are filtered before use, lagging the pin by filter rate plus two up to filter rate times two plus one.
// - Decisions on incoming bus levels are taken on the filter sample tick, not on SCL edges; the sequencer acts on the filtered levels every clock cycle.
// - The 6-bit divider select maps each code to a fixed ratio from 160 up to 61440.
// - Each distinct ratio yields its own distinct generated serial clock frequency.
// - After a start, SDA stays low for ratio/16 halved until below 16, or below 9 if bit 5 is set.
// - As master, data is set up before the rising clock for half the ratio minus the data hold.
// - Before a repeated start, clock and data stay high for the full ratio plus the start hold.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module i2c_bit_timing_divider (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire i2c_timing_pkg::wb_req_t wb_req_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic done_out
);
  import i2c_timing_pkg::*;

  // ------------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------------
  // ratio of a divider code; upper half runs from 160 to 32768
  function automatic logic [15:0] ratio_of(input logic [5:0] code);
    logic [5:0] idx;
    logic [15:0] base;
    idx = code - CODE_HI_SHIFT0;
    base = 16'h0000;
    if (code == CODE_TOP_LO)
      ratio_of = RATIO_TOP;
    else if (!code[5])
    begin
      case (code[1:0])
        2'b00: base = 16'h0120;
        2'b01: base = 16'h0140;
        2'b10: base = 16'h0180;
        default: base = 16'h01c0;
      endcase
      ratio_of = base << code[4:2];
    end
    else if (code < CODE_HI_SHIFT0)
    begin
      case (code[1:0])
        2'b00: base = 16'h00a0;
        2'b01: base = 16'h00c0;
        2'b10: base = 16'h00e0;
        default: base = 16'h0100;
      endcase
      ratio_of = base;
    end
    else
    begin
      case (idx[1:0])
        2'b00: base = 16'h0140;
        2'b01: base = 16'h0180;
        2'b10: base = 16'h01e0;
        default: base = 16'h0200;
      endcase
      ratio_of = base << idx[4:2];
    end
  endfunction : ratio_of

  // start hold: ratio/16 halved until under the limit picked by bit 5
  function automatic logic [15:0] start_hold_of(input logic [15:0] ratio, input logic b5);
    logic [15:0] v;
    logic [15:0] lim;
    v = ratio >> 4;
    lim = b5 ? SH_LIMIT_HI : SH_LIMIT_LO;
    for (int i = 0; i < SH_HALVINGS; i++)
    begin
      if (v >= lim)
        v = v >> 1;
    end
    start_hold_of = (v == 16'h0000) ? 16'h0001 : v;
  endfunction : start_hold_of

  // data hold after the falling clock edge
  function automatic logic [15:0] hold_of(input logic [5:0] code);
    logic [15:0] mult;
    case ({code[5], code[1]})
      2'b10: mult = 16'h0001;
      2'b11: mult = 16'h0002;
      2'b00: mult = 16'h0003;
      default: mult = 16'h0004;
    endcase
    hold_of = HOLD_BASE + ((HOLD_UNIT << code[4:2]) * mult);
  endfunction : hold_of

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [5:0] div_sel_q;
  logic [5:0] fsr_q;
  logic enable_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [5:0] fcnt_q;
  logic [1:0] samp1_q;
  logic [1:0] samp2_q;
  logic [1:0] qual_q;
  state_t state_q, state_d;
  op_t op_q, op_d;
  logic [16:0] cnt_q, cnt_d;
  logic scl_drv_q, scl_drv_d;
  logic sda_drv_q, sda_drv_d;
  logic bit_q, bit_d;
  logic rx_q, rx_d;
  logic done_q, done_d;
  logic [15:0] ratio_q, ratio_d;
  logic [15:0] sh_q, sh_d;
  logic [15:0] hold_q, hold_d;
  logic [16:0] low_len_q;
  logic [16:0] hi_len_q;
  logic [16:0] sh_len_q;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  wire req_w = wb_req_in.cyc && wb_req_in.stb && !ack_q;
  wire wr_w = req_w && wb_req_in.we;
  wire div_wr_w = wr_w && (wb_req_in.adr == DIV_REG_OFS);
  wire ctrl_wr_w = wr_w && (wb_req_in.adr == CTRL_REG_OFS) && wb_req_in.sel[0];
  wire cmd_go = wr_w && (wb_req_in.adr == CMD_REG_OFS) && wb_req_in.sel[0];
  wire op_t cmd_op = op_t'(wb_req_in.dat[CMD_OP_LSB +: 2]);
  wire cmd_bit = wb_req_in.dat[CMD_BIT_POS];
  wire scl_q = qual_q[0];
  wire sda_q = qual_q[1];

  wire [15:0] ratio_w = ratio_of(div_sel_q);
  // start hold from ratio and bit 5
  wire [15:0] sh_w = start_hold_of(ratio_w, div_sel_q[5]);
  // data hold from bits 5, 4..2 and 1
  wire [15:0] hold_w = hold_of(div_sel_q);
  wire [15:0] half_w = {1'b0, ratio_w[15:1]};
  wire [15:0] setup_w = (hold_w < half_w) ? (half_w - hold_w) : 16'h0001;

  // latched timing limits for the running transfer
  // half-ratio clock phase
  wire [16:0] half_lim = {2'b00, ratio_q[15:1]};
  wire [16:0] hold_lim = ({1'b0, hold_q} < half_lim) ? {1'b0, hold_q} : (half_lim - 17'h00001);
  // repeated start needs full ratio plus start hold high
  wire [16:0] rs_lim = {1'b0, ratio_q} + {1'b0, sh_q};
  wire [16:0] high_lim = (op_q == OP_RESTART) ? rs_lim : half_lim;
  wire [16:0] cnt_inc = cnt_q + 17'h00001;

  // read mux
  wire [31:0] rsel_w =
    (wb_req_in.adr == DIV_REG_OFS) ? {18'h00000, fsr_q, 2'b00, div_sel_q} :
    (wb_req_in.adr == CTRL_REG_OFS) ? {31'h00000000, enable_q} :
    (wb_req_in.adr == STAT_REG_OFS) ?
      {27'h0000000, (state_q == ST_PARK), sda_q, scl_q, rx_q, (state_q != ST_IDLE)} :
    (wb_req_in.adr == TIME0_REG_OFS) ? {hold_w, ratio_w} :
    (wb_req_in.adr == TIME1_REG_OFS) ? {setup_w, sh_w} : 32'h00000000;

  // ------------------------------------------------------------------
  // wishbone slave registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      div_sel_q <= DIV_SEL_RESET;
      fsr_q <= FSR_RESET;
      enable_q <= CTRL_EN_RESET;
    end
    else
    begin
      ack_q <= req_w;
      rdat_q <= req_w ? rsel_w : rdat_q;
      if (div_wr_w && wb_req_in.sel[0])
        div_sel_q <= wb_req_in.dat[DIV_SEL_LSB +: 6];
      if (div_wr_w && wb_req_in.sel[1])
        fsr_q <= wb_req_in.dat[FSR_LSB +: 6];
      if (ctrl_wr_w)
        enable_q <= wb_req_in.dat[CTRL_EN_POS];
    end
  end

  // ------------------------------------------------------------------
  // input filter
  // ------------------------------------------------------------------
  // sample tick every fsr cycles
  wire tick_w = (fcnt_q == 6'h00);

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      fcnt_q <= 6'h00;
    else if (tick_w)
      fcnt_q <= (fsr_q == 6'h00) ? 6'h00 : (fsr_q - 6'h01);
    else
      fcnt_q <= fcnt_q - 6'h01;
  end

  // two sample stages plus one output stage per line
  for (genvar g = 0; g < 2; g++)
  begin : g_filt
    wire raw_w = (g == 0) ? scl_in : sda_in;
    always_ff @(posedge clk_in or posedge reset_in)
    begin
      if (reset_in)
      begin
        samp1_q[g] <= 1'b1;
        samp2_q[g] <= 1'b1;
        qual_q[g] <= 1'b1;
      end
      else
      begin
        if (tick_w)
        begin
          samp1_q[g] <= raw_w;
          samp2_q[g] <= samp1_q[g];
        end
        if (samp1_q[g] == samp2_q[g])
          qual_q[g] <= samp2_q[g];
      end
    end
  end

  // ------------------------------------------------------------------
  // master bit sequencer
  // ------------------------------------------------------------------
  // every phase is a cycle count on the bus clock
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    scl_drv_d = scl_drv_q;
    sda_drv_d = sda_drv_q;
    bit_d = bit_q;
    rx_d = rx_q;
    done_d = 1'b0;
    ratio_d = ratio_q;
    sh_d = sh_q;
    hold_d = hold_q;
    case (state_q)
      ST_IDLE:
      begin
        scl_drv_d = 1'b0;
        sda_drv_d = 1'b0;
        if (cmd_go && cmd_op == OP_START && scl_q && sda_q)
        begin
          ratio_d = ratio_w;
          sh_d = sh_w;
          hold_d = hold_w;
          sda_drv_d = 1'b1;
          cnt_d = 17'h00000;
          state_d = ST_START_HOLD;
        end
      end
      ST_START_HOLD:
      begin
        cnt_d = cnt_inc;
        // data low for the start hold before the first clock
        if (cnt_inc == {1'b0, sh_q})
        begin
          scl_drv_d = 1'b1;
          done_d = 1'b1;
          state_d = ST_PARK;
        end
      end
      ST_PARK:
        if (cmd_go && cmd_op != OP_START)
        begin
          op_d = cmd_op;
          bit_d = cmd_bit;
          cnt_d = 17'h00000;
          state_d = ST_LOW;
        end
      ST_LOW:
      begin
        cnt_d = cnt_inc;
        // data changes once the hold count has elapsed
        if (cnt_inc == hold_lim)
          sda_drv_d = (op_q == OP_BIT) ? !bit_q : (op_q == OP_STOP);
        // low phase of half the ratio
        if (cnt_inc == half_lim)
        begin
          scl_drv_d = 1'b0;
          cnt_d = 17'h00000;
          state_d = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        // high time counts only from the qualified high level
        cnt_d = scl_q ? cnt_inc : 17'h00000;
        // data has stood since the hold point until here
        if (scl_q && cnt_inc == high_lim)
        begin
          cnt_d = 17'h00000;
          done_d = (op_q != OP_RESTART);
          case (op_q)
            OP_BIT:
            begin
              rx_d = sda_q;
              scl_drv_d = 1'b1;
              state_d = ST_PARK;
            end
            OP_STOP:
            begin
              sda_drv_d = 1'b0;
              state_d = ST_IDLE;
            end
            default:
            begin
              sda_drv_d = 1'b1;
              state_d = ST_START_HOLD;
            end
          endcase
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
    if (!enable_q)
    begin
      state_d = ST_IDLE;
      scl_drv_d = 1'b0;
      sda_drv_d = 1'b0;
    end
  end

  // sequencer and assertion helper registers
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_START;
      cnt_q <= 17'h00000;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
      bit_q <= 1'b0;
      rx_q <= 1'b0;
      done_q <= 1'b0;
      ratio_q <= 16'h0000;
      sh_q <= 16'h0000;
      hold_q <= 16'h0000;
      low_len_q <= 17'h00000;
      hi_len_q <= 17'h00000;
      sh_len_q <= 17'h00000;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      scl_drv_q <= scl_drv_d;
      sda_drv_q <= sda_drv_d;
      bit_q <= bit_d;
      rx_q <= rx_d;
      done_q <= done_d;
      ratio_q <= ratio_d;
      sh_q <= sh_d;
      hold_q <= hold_d;
      low_len_q <= scl_drv_q ? (low_len_q + 17'h00001) : 17'h00000;
      // saturates instead of wrapping during a long idle
      hi_len_q <= !scl_drv_q ? (hi_len_q + {16'h0000, !(&hi_len_q)}) : 17'h00000;
      sh_len_q <= (state_q == ST_START_HOLD) ? (sh_len_q + 17'h00001) : 17'h00000;
    end
  end

  // open-drain pins: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_drv_q;
  assign sda_oe_out = sda_drv_q;
  assign done_out = done_q;
  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_rs_release;
    state_q == ST_HIGH && op_q == OP_RESTART ##1 state_q == ST_START_HOLD;
  endsequence

  sequence s_start_done;
    state_q == ST_START_HOLD ##1 state_q == ST_PARK;
  endsequence

  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  a_ack_latency: assert property (req_w |=> wb_ack_out) else $error("ack not one cycle after request");
  a_ratio_code: assert property (div_sel_q == 6'h20 |-> ratio_w == 16'h00a0)
    else $error("code 0x20 does not give ratio 160");
  a_low_min_len: assert property ($fell(scl_oe_out) && state_q == ST_HIGH |-> low_len_q >= half_lim)
    else $error("clock low phase shorter than half ratio");
  a_high_min_len: assert property ($rose(scl_oe_out) && state_q == ST_PARK |-> hi_len_q >= half_lim)
    else $error("clock high phase shorter than half ratio");
  a_start_hold_len: assert property (s_start_done |-> sh_len_q == {1'b0, sh_q} && sda_oe_out)
    else $error("start hold length wrong");
  a_data_hold_pt: assert property (state_q == ST_LOW && $changed(sda_oe_out) |-> cnt_q == hold_lim)
    else $error("data changed away from hold point");
  a_restart_setup: assert property (s_rs_release |-> hi_len_q >= rs_lim && sda_oe_out)
    else $error("repeated start setup too short");
  // sample stages move only on the sample tick
  a_filter_on_tick: assert property ($changed(samp2_q) |-> $past(tick_w))
    else $error("filter stage moved without sample tick");

endmodule : i2c_bit_timing_divider

`default_nettype wire

// *** dv/i2c_far_side.sv ***
// far-side bus receiver model that may acknowledge by pulling data low
`timescale 1ns/100ps
`default_nettype none

module i2c_far_side (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic scl_line_in,
  input wire logic ack_in,
  input wire logic hold_low_in,
  output logic sda_pull_out
);
  logic ack_pull_q;

  // ----------------------------------------------------------------
  // data pull
  // ----------------------------------------------------------------
  // the clock is never touched, so its periods stay the device's own
  // acknowledge only changes while the clock line is low; starts released
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      ack_pull_q <= 1'b0;
    else if (scl_line_in == 1'b0)
      ack_pull_q <= ack_in;
  end

  // another bus user holding data low, as seen by a start attempt
  assign sda_pull_out = ack_pull_q | hold_low_in;
endmodule : i2c_far_side
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench of the bit timing block
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import i2c_timing_pkg::*;
  typedef struct {logic [5:0] code; logic [31:0] t0; logic [31:0] t1;} row_t;
  logic clk_in, reset_in, scl_out, scl_oe_out, sda_out, sda_oe_out, done_out, wb_ack_out;
  logic ack, pull, hold_low;
  logic [31:0] wb_dat_out, q;
  wb_req_t req;
  int fail_count, compares, dones, n, m;
  row_t rows [6];
  wire logic scl_line = !scl_oe_out;
  wire logic sda_line = !(sda_oe_out | pull);

  i2c_bit_timing_divider dut (.clk_in(clk_in), .reset_in(reset_in), .wb_req_in(req),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .done_out(done_out));
  i2c_far_side far (.clk_in(clk_in), .reset_in(reset_in), .scl_line_in(scl_line),
    .ack_in(ack), .hold_low_in(hold_low), .sda_pull_out(pull));

  // ----------------------------------------------------------------
  // clock and done counter
  // ----------------------------------------------------------------
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) if (done_out === 1'b1) dones <= dones + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rng(input int v, input int lo, input int hi);
    chk({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
  endtask : rng

  // classic wishbone single cycle, holds until ack sampled at an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    do
    begin
      @(posedge clk_in);
      k++;
    end
    while (wb_ack_out !== 1'b1 && k < 50);
    q = wb_dat_out;
    req <= '0;
    if (k >= 50)
    begin
      fail_count++;
      $display("MISMATCH at %0t: no bus answer", $time);
      complete_run();
    end
  endtask : wb

  function automatic logic pin(input int s);
    return (s == 0) ? sda_oe_out : scl_oe_out;
  endfunction : pin

  // counts edges until an enable shows the wanted level
  task automatic wait_lvl(input int s, input logic lvl, output int c);
    c = 0;
    do
    begin
      @(posedge clk_in);
      c++;
    end
    while (pin(s) !== lvl && c < 40000);
    if (c >= 40000)
    begin
      fail_count++;
      $display("MISMATCH at %0t: wait timed out", $time);
      complete_run();
    end
  endtask : wait_lvl

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    reset_in = 1'b1;
    req = '0;
    ack = 1'b0;
    hold_low = 1'b0;
    dones = 0;
    rows[0] = '{6'h20, 32'h0018_00a0, 32'h0038_0005};
    rows[1] = '{6'h00, 32'h0038_0120, 32'h0058_0009};
    rows[2] = '{6'h01, 32'h0038_0140, 32'h0068_000a};
    rows[3] = '{6'h1f, 32'h2008_f000, 32'h57f8_000f};
    rows[4] = '{6'h3f, 32'h1008_8000, 32'h2ff8_0008};
    rows[5] = '{6'h2a, 32'h0088_03c0, 32'h0158_0007};
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    // reset values and an unmapped place
    wb(1'b0, DIV_REG_OFS, 32'h0);
    chk(q, 32'h0000_1000);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, CTRL_REG_OFS, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, CMD_REG_OFS, 32'h0);
    chk(q, 32'h0);
    // ratio, hold, start hold and setup per divider code
    foreach (rows[i])
    begin
      wb(1'b1, DIV_REG_OFS, {24'h4, 2'b00, rows[i].code});
      wb(1'b0, TIME0_REG_OFS, 32'h0);
      chk(q, rows[i].t0);
      wb(1'b0, TIME1_REG_OFS, 32'h0);
      chk(q, rows[i].t1);
    end
    // start refused while the far side holds data low
    wb(1'b1, DIV_REG_OFS, 32'h0000_0420);
    wb(1'b1, CTRL_REG_OFS, 32'h1);
    hold_low <= 1'b1;
    repeat (30) @(posedge clk_in);
    wb(1'b1, CMD_REG_OFS, 32'h0);
    repeat (40) @(posedge clk_in);
    chk(sda_oe_out, 1'b0);
    chk(dones, 0);
    hold_low <= 1'b0;
    repeat (30) @(posedge clk_in);
    // start, then a released bit with timed phases
    wb(1'b1, CMD_REG_OFS, 32'h0);
    wait_lvl(0, 1'b1, n);
    wait_lvl(1, 1'b1, n);
    // data fell before the bus answer, so this wait starts one edge into the hold
    rng(n + 1, 5, 6);
    wb(1'b1, CMD_REG_OFS, 32'h11);
    wait_lvl(0, 1'b0, n);
    rng(n, 22, 27);
    wait_lvl(1, 1'b0, m);
    rng(m, 54, 58);
    rng(n + m, 78, 84);
    wait_lvl(1, 1'b1, n);
    // half ratio plus filter lag, which runs from rate+2 to rate*2+1 by tick phase
    rng(n, 86, 89);
    wb(1'b0, STAT_REG_OFS, 32'h0);
    chk(q[1], 1'b1);
    // released bit that the far side acknowledges
    ack <= 1'b1;
    repeat (3) @(posedge clk_in);
    wb(1'b1, CMD_REG_OFS, 32'h11);
    wait_lvl(1, 1'b0, n);
    wait_lvl(1, 1'b1, n);
    wb(1'b0, STAT_REG_OFS, 32'h0);
    chk(q[1], 1'b0);
    ack <= 1'b0;
    repeat (3) @(posedge clk_in);
    // repeated start then stop
    wb(1'b1, CMD_REG_OFS, 32'h3);
    wait_lvl(1, 1'b0, n);
    wait_lvl(0, 1'b1, n);
    rng(n, 165, 180);
    wait_lvl(1, 1'b1, n);
    rng(n, 5, 6);
    wb(1'b1, CMD_REG_OFS, 32'h2);
    wait_lvl(1, 1'b0, n);
    wait_lvl(0, 1'b0, n);
    rng(n, 80, 96);
    repeat (3) @(posedge clk_in);
    chk(dones, 5);
    wb(1'b0, STAT_REG_OFS, 32'h0);
    chk(q[0], 1'b0);
    // disable in mid start releases both lines; let the released data qualify first
    repeat (10) @(posedge clk_in);
    wb(1'b1, CMD_REG_OFS, 32'h0);
    chk(sda_oe_out, 1'b1);
    wb(1'b1, CTRL_REG_OFS, 32'h0);
    repeat (3) @(posedge clk_in);
    chk({sda_oe_out, scl_oe_out}, 2'b00);
    chk({scl_out, sda_out}, 2'b00);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
